// >>> rtl/jtag_tap_pkg.sv
// Constants, opcodes and state type shared by the test access port
package jtag_tap_pkg;
    localparam int IR_WIDTH = 5;
    localparam int ID_WIDTH = 32;
    localparam int BS_LEN = 8;
    localparam int TMS_RESET_COUNT = 5;
    localparam logic [2:0] TMS_CNT_MAX = 3'h5;
    localparam logic [2:0] TMS_CNT_ONE = 3'h1;
    localparam logic [1:0] IR_CAPTURE_LSBS = 2'h1;
    // Arbitrary identification value, bit 0 set as the standard requires
    localparam logic [ID_WIDTH-1:0] ID_CODE = 32'h0000_0001;
    localparam logic [IR_WIDTH-1:0] OP_IDCODE = 5'h01;
    localparam logic [IR_WIDTH-1:0] OP_SAMPLE_PRELOAD = 5'h02;
    localparam logic [IR_WIDTH-1:0] OP_EXTEST = 5'h03;
    localparam logic [IR_WIDTH-1:0] OP_INTEST = 5'h04;
    localparam logic [IR_WIDTH-1:0] OP_CLAMP = 5'h06;
    localparam logic [IR_WIDTH-1:0] OP_STATIC_RESET = 5'h0c;
    localparam logic [IR_WIDTH-1:0] OP_SAB_FIRST = 5'h10;
    localparam logic [IR_WIDTH-1:0] OP_SAB_LAST = 5'h15;
    localparam logic [IR_WIDTH-1:0] OP_BYPASS = 5'h1f;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;
endpackage

// >>> rtl/jtag_tap_boundary_scan.sv
// Test access port with instruction register, data registers and boundary scan
//
// Functional notes
// - Test clock low at reset-pin release enables test port and takes the pins.
// - Test clock high at reset-pin release returns pins to normal use.
// - Enabling the port sets halt; a halt command writing zero clears it.
// - While the reset pin is low the port does nothing.
// - Five test-mode-select highs reach Test-Logic-Reset from any state.
// - From Test-Logic-Reset one low test-mode-select reaches Run-Test/Idle.
// - Both shift states shift least significant bit first, data in, data out.
// - Data out is released in all states but the two shift states.
// - Five-bit instruction register selects the data register for Shift-DR.
// - Instruction shift returns status bits, not the previous instruction.
// - Mode-select 1,1,0 returns to idle; instruction takes effect in Update-IR.
// - Values captured in Capture-DR shift out while new bits shift in.
// - Latched outputs update only in Update-DR; exit and pause states are inert.
// - Identification is the default instruction after reset.
// - With EXTEST loaded, latch values drive pins and pins are sampled.
// - Boundary scan runs on the sampling clock; test clock edges are detected from it.
// - Service-bus instructions keep system clocks running through sleep.
// - While pins serve the test port their peripheral functions are disabled.
// - Inputs sampled on rising test clock; data out changes on falling edge.
// - Opcode 0x01 selects the 32-bit identification register.
`timescale 1ns/10ps
module jtag_tap_boundary_scan (
    input wire logic clk, // Sampling clock, 20 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic clkEn, // Freezes all state while low
    input wire logic resetPinN, // External reset pin, active low
    input wire logic tckPin, // Test clock pin
    input wire logic tmsPin, // Test mode select pin
    input wire logic tdiPin, // Test data in pin
    output logic tdoOut, // Test data out value
    output logic tdoOeN, // Test data out enable, low while driving
    output logic testPortEn, // Multiplexed pins serve the test port
    output logic peripheralDisable, // Normal pin functions switched off
    output logic haltFlag, // Processor halt request
    input wire logic haltCmdValid, // Halt command from the service side
    input wire logic haltCmdValue, // Halt value written by that command
    input wire logic [2:0] irStatus, // Status bits shown during instruction shift
    output logic keepClocksOn, // Keep system clocks through sleep
    output logic staticReset, // Static reset held on the core
    output logic [jtag_tap_pkg::IR_WIDTH-1:0] activeIr, // Current instruction
    input wire logic [jtag_tap_pkg::BS_LEN-1:0] pinIn, // Levels seen on the pins
    input wire logic [jtag_tap_pkg::BS_LEN-1:0] coreOut, // Values the core drives
    output logic [jtag_tap_pkg::BS_LEN-1:0] pinOut // Values going to the pads
);
    import jtag_tap_pkg::*;

    // Pin synchronisers; the first stage feeds only the second
    logic resetMeta, resetSync;
    logic tckMeta, tckSync, tckPrev;
    logic tmsMeta, tmsSync;
    logic tdiMeta, tdiSync;
    logic [BS_LEN-1:0] pinMeta, pinSync;
    logic resetPrev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resetMeta <= 1'b0;
            resetSync <= 1'b0;
            resetPrev <= 1'b0;
            tckMeta <= 1'b0;
            tckSync <= 1'b0;
            tckPrev <= 1'b0;
            tmsMeta <= 1'b1;
            tmsSync <= 1'b1;
            tdiMeta <= 1'b0;
            tdiSync <= 1'b0;
            pinMeta <= '0;
            pinSync <= '0;
        end else if (clkEn) begin
            resetMeta <= resetPinN;
            resetSync <= resetMeta;
            resetPrev <= resetSync;
            tckMeta <= tckPin;
            tckSync <= tckMeta;
            tckPrev <= tckSync;
            tmsMeta <= tmsPin;
            tmsSync <= tmsMeta;
            tdiMeta <= tdiPin;
            tdiSync <= tdiMeta;
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    logic resetRelease, tapActive, tckRise, tckFall, rise, fall;
    assign resetRelease = resetSync && !resetPrev;
    assign tckRise = tckSync && !tckPrev;
    assign tckFall = !tckSync && tckPrev;
    // Nothing moves while the reset pin is low or the port is off
    assign tapActive = testPortEn && resetSync;
    assign rise = clkEn && tapActive && tckRise;
    assign fall = clkEn && tapActive && tckFall;

    // Port enable is strapped by the test clock level at reset-pin release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            testPortEn <= 1'b0;
        end else if (clkEn && resetRelease) begin
            testPortEn <= !tckSync;
        end
    end
    assign peripheralDisable = testPortEn;

    logic enPrev;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enPrev <= 1'b0;
            haltFlag <= 1'b0;
        end else if (clkEn) begin
            enPrev <= testPortEn;
            // Setting on enable wins over a clearing command in the same cycle
            if (testPortEn && !enPrev) begin
                haltFlag <= 1'b1;
            end else if (haltCmdValid) begin
                haltFlag <= haltCmdValue;
            end
        end
    end

    // Controller state machine
    tap_state_t tapState, next_tapState;
    always_comb begin
        case (tapState)
            TEST_LOGIC_RESET: next_tapState = tmsSync ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: next_tapState = tmsSync ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: next_tapState = tmsSync ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: next_tapState = tmsSync ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_tapState = tmsSync ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_tapState = tmsSync ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: next_tapState = tmsSync ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_tapState = tmsSync ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: next_tapState = tmsSync ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: next_tapState = tmsSync ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: next_tapState = tmsSync ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_tapState = tmsSync ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_tapState = tmsSync ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: next_tapState = tmsSync ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_tapState = tmsSync ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: next_tapState = tmsSync ? SELECT_DR : RUN_TEST_IDLE;
            default: next_tapState = TEST_LOGIC_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tapState <= TEST_LOGIC_RESET;
        end else if (clkEn && !testPortEn) begin
            tapState <= TEST_LOGIC_RESET;
        end else if (rise) begin
            tapState <= next_tapState;
        end
    end

    // Instruction register
    logic [IR_WIDTH-1:0] irShift;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irShift <= '0;
            activeIr <= OP_IDCODE;
        end else if (clkEn && tapState == TEST_LOGIC_RESET) begin
            // Held here while the port is off too, so a stale EXTEST cannot keep the pins
            activeIr <= OP_IDCODE;
        end else if (rise) begin
            case (tapState)
                CAPTURE_IR: irShift <= {irStatus, IR_CAPTURE_LSBS};
                SHIFT_IR: irShift <= {tdiSync, irShift[IR_WIDTH-1:1]};
                UPDATE_IR: activeIr <= irShift;
                default: irShift <= irShift;
            endcase
        end
    end

    logic selId, selBs, selRst, irIsSab, bsDrivesPins;
    assign selId = (activeIr == OP_IDCODE);
    assign selBs = (activeIr == OP_SAMPLE_PRELOAD) || (activeIr == OP_EXTEST)
        || (activeIr == OP_INTEST);
    assign selRst = (activeIr == OP_STATIC_RESET);
    assign irIsSab = (activeIr >= OP_SAB_FIRST) && (activeIr <= OP_SAB_LAST);
    assign bsDrivesPins = (activeIr == OP_EXTEST) || (activeIr == OP_INTEST)
        || (activeIr == OP_CLAMP);
    // Sleep would otherwise stop the clock that the service bus needs
    assign keepClocksOn = irIsSab;

    // Data registers; anything not decoded falls back to bypass
    logic [ID_WIDTH-1:0] idShift;
    logic [BS_LEN-1:0] bsShift, bsLatch;
    logic bypassShift, rstShift;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idShift <= '0;
            bsShift <= '0;
            bypassShift <= 1'b0;
            rstShift <= 1'b0;
        end else if (rise && tapState == CAPTURE_DR) begin
            idShift <= ID_CODE;
            bsShift <= (activeIr == OP_INTEST) ? coreOut : pinSync;
            bypassShift <= 1'b0;
            rstShift <= staticReset;
        end else if (rise && tapState == SHIFT_DR) begin
            if (selId) begin
                idShift <= {tdiSync, idShift[ID_WIDTH-1:1]};
            end else if (selBs) begin
                bsShift <= {tdiSync, bsShift[BS_LEN-1:1]};
            end else if (selRst) begin
                rstShift <= tdiSync;
            end else begin
                bypassShift <= tdiSync;
            end
        end
    end

    // Latched outputs change only on leaving Update-DR
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bsLatch <= '0;
            staticReset <= 1'b0;
        end else if (rise && tapState == UPDATE_DR) begin
            if (selBs) begin
                bsLatch <= bsShift;
            end
            if (selRst) begin
                staticReset <= rstShift;
            end
        end
    end

    // Scan registers run on the sampling clock, so scan needs it running as well as the test clock
    assign pinOut = bsDrivesPins ? bsLatch : coreOut;

    logic drBit;
    always_comb begin
        if (selId) begin
            drBit = idShift[0];
        end else if (selBs) begin
            drBit = bsShift[0];
        end else if (selRst) begin
            drBit = rstShift;
        end else begin
            drBit = bypassShift;
        end
    end

    // Data out moves on the falling edge, half a period after the shift
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdoOut <= 1'b0;
            tdoOeN <= 1'b1;
        end else if (clkEn && !tapActive) begin
            tdoOeN <= 1'b1;
        end else if (fall) begin
            tdoOeN <= !(tapState == SHIFT_IR || tapState == SHIFT_DR);
            tdoOut <= (tapState == SHIFT_IR) ? irShift[0] : drBit;
        end
    end

    // Checking helpers
    logic [2:0] tmsHighCnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmsHighCnt <= '0;
        end else if (rise) begin
            if (!tmsSync) begin
                tmsHighCnt <= '0;
            end else if (tmsHighCnt != TMS_CNT_MAX) begin
                tmsHighCnt <= tmsHighCnt + TMS_CNT_ONE;
            end
        end
    end

    tmsResetReach_a: assert property (@(posedge clk) disable iff (rst)
        (tmsHighCnt == TMS_CNT_MAX) |-> (tapState == TEST_LOGIC_RESET))
        else $error("Five mode-select highs did not reach Test-Logic-Reset");

    idleEntry_a: assert property (@(posedge clk) disable iff (rst)
        (rise && tapState == TEST_LOGIC_RESET && !tmsSync) |=> (tapState == RUN_TEST_IDLE))
        else $error("Low mode-select in reset state did not reach idle");

    tdoRelease_a: assert property (@(posedge clk) disable iff (rst)
        (fall && tapState != SHIFT_IR && tapState != SHIFT_DR) |=> tdoOeN)
        else $error("Data out driven outside shift states");

    irUpdateOnly_a: assert property (@(posedge clk) disable iff (rst)
        (activeIr != $past(activeIr)) |->
        ($past(tapState) == UPDATE_IR || $past(tapState) == TEST_LOGIC_RESET))
        else $error("Instruction changed outside Update-IR");

    irStatusCapture_a: assert property (@(posedge clk) disable iff (rst)
        (rise && tapState == CAPTURE_IR) |=> (irShift == {$past(irStatus), IR_CAPTURE_LSBS}))
        else $error("Instruction capture did not load status bits");

    idDefault_a: assert property (@(posedge clk) disable iff (rst)
        (rise && tapState == TEST_LOGIC_RESET) |=> (activeIr == OP_IDCODE))
        else $error("Identification not default after reset state");

    extestDrive_a: assert property (@(posedge clk) disable iff (rst)
        (activeIr == OP_EXTEST) |-> (pinOut == bsLatch))
        else $error("Pins not driven from boundary latch under EXTEST");

    latchUpdate_a: assert property (@(posedge clk) disable iff (rst)
        (bsLatch != $past(bsLatch)) |-> ($past(tapState) == UPDATE_DR && $past(rise)))
        else $error("Boundary latch changed outside Update-DR");

    haltOnEnable_a: assert property (@(posedge clk) disable iff (rst)
        (clkEn && testPortEn && !enPrev) |=> haltFlag)
        else $error("Halt not set when test port enabled");

    portStrap_a: assert property (@(posedge clk) disable iff (rst)
        (clkEn && resetRelease && !tckSync) |=> (testPortEn && peripheralDisable))
        else $error("Test port not enabled by low test clock at release");

    quietInReset_a: assert property (@(posedge clk) disable iff (rst)
        (!resetSync && testPortEn) |=> (tapState == $past(tapState)))
        else $error("Controller moved while reset pin low");

    sabClocks_a: assert property (@(posedge clk) disable iff (rst)
        (rise && tapState == UPDATE_IR && irShift >= OP_SAB_FIRST && irShift <= OP_SAB_LAST)
        |=> keepClocksOn)
        else $error("Clocks not kept for service-bus instruction");

    tdoFallOnly_a: assert property (@(posedge clk) disable iff (rst)
        (tdoOut != $past(tdoOut)) |-> $past(fall))
        else $error("Data out changed away from a falling test clock");

    tdoDriveShift_a: assert property (@(posedge clk) disable iff (rst)
        (fall && (tapState == SHIFT_IR || tapState == SHIFT_DR)) |=> !tdoOeN)
        else $error("Data out not driven in a shift state");

    irStatusOut_a: assert property (@(posedge clk) disable iff (rst)
        (fall && tapState == SHIFT_IR) |=> (tdoOut == $past(irShift[0])))
        else $error("Instruction shift did not show status on data out");

    idShiftIn_a: assert property (@(posedge clk) disable iff (rst)
        (rise && tapState == SHIFT_DR && selId) |=> (idShift[ID_WIDTH-1] == $past(tdiSync)))
        else $error("Identification register did not take data in at the top");

    portOffIdle_a: assert property (@(posedge clk) disable iff (rst)
        (clkEn && !testPortEn) |=> (tapState == TEST_LOGIC_RESET && tdoOeN))
        else $error("Disabled test port left the controller running");

endmodule // jtag_tap_boundary_scan

// >>> verif/jtag_host_model.sv
// Behavioural external test controller driving the test clock, mode select and data in
`timescale 1ns/10ps
module jtag_host_model (
    input wire logic clk, // Bench clock
    output logic tck, // Test clock, stands still between bits
    output logic tms, // Mode select
    output logic tdi, // Data in
    input wire logic tdoOut, // Data out value
    input wire logic tdoOeN // Data out enable, low while driven
);
    logic lastTdo = 1'b0;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic park(input logic lvl);
        @(posedge clk) tck <= lvl;
    endtask
    // Fall, hold low five clocks, then rise: mode and data settle long before the rise
    task automatic clockBit(input logic m, input logic d, output logic q);
        @(posedge clk) tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        #1;
        // A released line shows the inverse of its last level, never a held value
        lastTdo = tdoOeN ? ~lastTdo : tdoOut;
        q = lastTdo;
        @(posedge clk) tck <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic nav(input logic m);
        logic q;
        clockBit(m, ~tdi, q);
    endtask
    task automatic tapReset();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask
    // Ends in the exit state so the caller can look before the update
    task automatic scan(input logic ir, input int len, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < len; i++) begin
            clockBit(i == len - 1, din[i], q);
            dout[i] = q;
        end
    endtask
    task automatic finish();
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule // jtag_host_model

// >>> verif/testbench.sv
// Self-checking bench for the test access port
`timescale 1ns/10ps
module testbench;
    import jtag_tap_pkg::*;
    logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, resetPinN = 1'b0;
    logic haltCmdValid = 1'b0, haltCmdValue = 1'b0;
    logic [2:0] irStatus = 3'h5;
    logic [BS_LEN-1:0] pinIn = 8'h3c, coreOut = 8'h96, pinOut;
    logic tckPin, tmsPin, tdiPin, tdoOut, tdoOeN, testPortEn, peripheralDisable;
    logic haltFlag, keepClocksOn, staticReset;
    logic [IR_WIDTH-1:0] activeIr;
    logic [31:0] got;
    int errCount = 0, checksDone = 0;
    jtag_tap_boundary_scan dut (.clk(clk), .rst(rst), .clkEn(clkEn), .resetPinN(resetPinN),
        .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin), .tdoOut(tdoOut), .tdoOeN(tdoOeN),
        .testPortEn(testPortEn), .peripheralDisable(peripheralDisable), .haltFlag(haltFlag),
        .haltCmdValid(haltCmdValid), .haltCmdValue(haltCmdValue), .irStatus(irStatus),
        .keepClocksOn(keepClocksOn), .staticReset(staticReset), .activeIr(activeIr),
        .pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut));
    jtag_host_model host (.clk(clk), .tck(tckPin), .tms(tmsPin), .tdi(tdiPin),
        .tdoOut(tdoOut), .tdoOeN(tdoOeN));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic haltCmd(input logic v);
        @(posedge clk) haltCmdValid <= 1'b1;
        haltCmdValue <= v;
        @(posedge clk) haltCmdValid <= 1'b0;
        settle();
    endtask
    task automatic irLoad(input logic [IR_WIDTH-1:0] op);
        host.scan(1'b1, IR_WIDTH, {27'h0, op}, got);
        host.finish();
        settle();
    endtask
    task automatic testEnable();
        @(posedge clk) resetPinN <= 1'b1;
        repeat (8) @(posedge clk);
        chk("testPortEn", 1, testPortEn);
        chk("peripheralDisable", 1, peripheralDisable);
        chk("haltFlag", 1, haltFlag);
        // A command while the clock enable is low must leave the flag alone
        @(posedge clk) clkEn <= 1'b0;
        haltCmd(1'b0);
        chk("frozenHalt", 1, haltFlag);
        clkEn <= 1'b1;
        haltCmd(1'b0);
        chk("haltFlag", 0, haltFlag);
        haltCmd(1'b1);
        chk("haltFlag", 1, haltFlag);
        haltCmd(1'b0);
        chk("haltFlag", 0, haltFlag);
        $display("enable done");
    endtask
    task automatic testIdcode();
        host.nav(1'b1);
        host.nav(1'b0);
        host.nav(1'b0);
        host.tapReset();
        chk("tdoOeN", 1, tdoOeN);
        host.scan(1'b0, ID_WIDTH, 32'h0, got);
        host.finish();
        chk("idcode", ID_CODE, got);
        $display("idcode done");
    endtask
    task automatic testIr();
        irStatus <= 3'h2;
        host.scan(1'b1, IR_WIDTH, {27'h0, OP_SAMPLE_PRELOAD}, got);
        chk("irCapture", {27'h0, irStatus, 2'h1}, got);
        host.nav(1'b1);
        chk("activeIr", OP_IDCODE, activeIr);
        host.nav(1'b0);
        settle();
        chk("activeIr", OP_SAMPLE_PRELOAD, activeIr);
        $display("instruction done");
    endtask
    task automatic testBoundary();
        host.scan(1'b0, BS_LEN, 32'ha5, got);
        host.finish();
        chk("sample", 32'h3c, got);
        chk("pinOut", coreOut, pinOut);
        irLoad(OP_EXTEST);
        chk("pinOut", 32'ha5, pinOut);
        pinIn <= 8'hc3;
        host.scan(1'b0, BS_LEN, 32'h5a, got);
        chk("extestSample", 32'hc3, got);
        chk("pinOut", 32'ha5, pinOut);
        host.finish();
        settle();
        chk("pinOut", 32'h5a, pinOut);
        $display("boundary done");
    endtask
    task automatic testInternal();
        coreOut <= 8'h69;
        irLoad(OP_INTEST);
        chk("pinOut", 32'h5a, pinOut);
        host.scan(1'b0, BS_LEN, 32'h0f, got);
        host.finish();
        settle();
        chk("intestCapture", 32'h69, got);
        chk("pinOut", 32'h0f, pinOut);
        irLoad(OP_CLAMP);
        chk("pinOut", 32'h0f, pinOut);
        // Clamp shifts through the one-stage bypass and leaves the latch alone
        host.scan(1'b0, 2, 32'h1, got);
        host.finish();
        settle();
        chk("clampBypass", 32'h2, got);
        chk("pinOut", 32'h0f, pinOut);
        $display("internal done");
    endtask
    task automatic testService();
        irLoad(OP_SAB_FIRST);
        chk("keepClocksOn", 1, keepClocksOn);
        irLoad(OP_SAB_LAST);
        chk("keepClocksOn", 1, keepClocksOn);
        irLoad(OP_BYPASS);
        chk("keepClocksOn", 0, keepClocksOn);
        // One stage of delay, first bit out is the captured zero
        host.scan(1'b0, 2, 32'h1, got);
        host.finish();
        chk("bypass", 32'h2, got);
        $display("service done");
    endtask
    task automatic testStatic();
        irLoad(OP_STATIC_RESET);
        host.scan(1'b0, 1, 32'h1, got);
        host.finish();
        settle();
        chk("staticReset", 1, staticReset);
        host.scan(1'b0, 1, 32'h0, got);
        host.finish();
        settle();
        chk("resetCapture", 1, got);
        chk("staticReset", 0, staticReset);
        $display("static reset done");
    endtask
    task automatic testResetPin();
        irLoad(OP_EXTEST);
        host.scan(1'b0, 1, 32'h1, got);
        chk("tdoOeN", 0, tdoOeN);
        @(posedge clk) resetPinN <= 1'b0;
        settle();
        // The release lands on the third edge, so look one edge later
        @(posedge clk);
        chk("tdoOeN", 1, tdoOeN);
        chk("pinOut", 32'h0f, pinOut);
        host.park(1'b1);
        repeat (4) @(posedge clk);
        resetPinN <= 1'b1;
        repeat (8) @(posedge clk);
        chk("testPortEn", 0, testPortEn);
        chk("peripheralDisable", 0, peripheralDisable);
        chk("pinOut", coreOut, pinOut);
        $display("reset pin done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        testEnable();
        testIdcode();
        testIr();
        testBoundary();
        testInternal();
        testService();
        testStatic();
        testResetPin();
        summarize();
    end
    initial begin
        // Whole sequence needs under two thousand clocks; this leaves ample margin
        repeat (30000) @(posedge clk);
        errCount++;
        summarize();
    end
endmodule // testbench
